/* rtl/seq_ctrl_pkg.sv */
// Shared constants for the sequencer reset, clocking and index logic
`default_nettype none
package seq_ctrl_pkg;
  // I/O port addresses
  localparam logic [15:0] IO_INDEX_PORT    = 16'h03C4;
  localparam logic [15:0] IO_DATA_PORT     = 16'h03C5;
  // Index values on the data port
  localparam logic [5:0]  IDX_RESET_CTRL   = 6'h00;
  localparam logic [5:0]  IDX_CLK_MODE     = 6'h01;
  localparam logic [5:0]  IDX_STD_LAST     = 6'h05;
  localparam logic [4:0]  IDX_CURSOR_HORIZ = 5'h10;
  localparam logic [4:0]  IDX_CURSOR_VERT  = 5'h11;
  // Reset values
  localparam logic [7:0]  INDEX_RESET      = 8'h04;
  localparam logic [7:0]  RESET_CTRL_RESET = 8'h00;
  localparam logic [7:0]  CLK_MODE_RESET   = 8'h00;
  // Writable bit masks, reserved bits read zero
  localparam logic [7:0]  RESET_CTRL_MASK  = 8'h03;
  localparam logic [7:0]  CLK_MODE_MASK    = 8'h3D;
  // Reset control fields
  localparam int          RST_ASYNC_BIT    = 0;
  localparam int          RST_SYNC_BIT     = 1;
  // Clocking mode fields
  localparam int          CM_EIGHT_DOT_BIT = 0;
  localparam int          CM_LOAD16_BIT    = 2;
  localparam int          CM_DIV2_BIT      = 3;
  localparam int          CM_LOAD32_BIT    = 4;
  localparam int          CM_FULL_BW_BIT   = 5;
  // Index register fields
  localparam int          FINE_LSB         = 5;
  // Character clock widths in dots, as last dot count
  localparam logic [3:0]  LAST_DOT_NINE    = 4'h8;
  localparam logic [3:0]  LAST_DOT_EIGHT   = 4'h7;
  // Shifter load periods in character clocks, as last count
  localparam logic [1:0]  LOAD_LAST_EVERY  = 2'h0;
  localparam logic [1:0]  LOAD_LAST_SECOND = 2'h1;
  localparam logic [1:0]  LOAD_LAST_FOURTH = 2'h3;
endpackage
`default_nettype wire

/* rtl/seq_clock_gen.sv */
// Dot, character and shifter load enable generator
`default_nettype none
module seq_clock_gen (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Control
  input  wire logic run,
  input  wire logic divBy2,
  input  wire logic eightDot,
  input  wire logic load16,
  input  wire logic load32,
  // Enables
  output logic      dotEn,
  output logic      charEn,
  output logic      loadEn
);
  logic       divPhase_reg;
  logic [3:0] dotCnt_reg;
  logic [1:0] charCnt_reg;
  logic       dotTick;
  logic       charTick;
  logic [3:0] lastDot;
  logic [1:0] loadLast;

  assign dotTick = run && (!divBy2 || divPhase_reg);
  assign lastDot = eightDot ? seq_ctrl_pkg::LAST_DOT_EIGHT
                            : seq_ctrl_pkg::LAST_DOT_NINE;
  assign charTick = dotTick && (dotCnt_reg == lastDot);
  assign loadLast = load32 ? seq_ctrl_pkg::LOAD_LAST_FOURTH :
                    load16 ? seq_ctrl_pkg::LOAD_LAST_SECOND :
                             seq_ctrl_pkg::LOAD_LAST_EVERY;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      divPhase_reg <= 1'b0;
    end else if (!run) begin
      divPhase_reg <= 1'b0;
    end else begin
      divPhase_reg <= !divPhase_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dotCnt_reg <= 4'h0;
    end else if (!run) begin
      dotCnt_reg <= 4'h0;
    end else if (charTick || dotCnt_reg > lastDot) begin
      dotCnt_reg <= 4'h0;
    end else if (dotTick) begin
      dotCnt_reg <= dotCnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      charCnt_reg <= 2'h0;
    end else if (!run) begin
      charCnt_reg <= 2'h0;
    end else if (charCnt_reg > loadLast) begin
      charCnt_reg <= 2'h0;
    end else if (charTick) begin
      charCnt_reg <= (charCnt_reg >= loadLast) ? 2'h0
                                               : charCnt_reg + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dotEn  <= 1'b0;
      charEn <= 1'b0;
      loadEn <= 1'b0;
    end else begin
      dotEn  <= dotTick;
      charEn <= charTick;
      loadEn <= charTick && (charCnt_reg == 2'h0);
    end
  end

  AST_DOT_UNDIVIDED: assert property (@(posedge clk)
    disable iff (!rst_b)
    run && !divBy2 |=> dotEn)
    else $error("dot enable missing with undivided clock");

  AST_DOT_HALVED: assert property (@(posedge clk)
    disable iff (!rst_b)
    $past(divBy2) && divBy2 && dotEn |=> !dotEn)
    else $error("dot enable too fast when divided");
endmodule
`default_nettype wire

/* rtl/seq_reset_clock_ctrl.sv */
// Sequencer index, reset control and clocking mode registers
`default_nettype none
module seq_reset_clock_ctrl (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Host I/O access
  input  wire logic [15:0] ioAddr,
  input  wire logic        ioWrStb,
  input  wire logic        ioRdStb,
  input  wire logic [7:0]  ioWrData,
  output logic      [7:0]  ioRdData,
  output logic             ioRdValid,
  // Extension register set
  output logic      [5:0]  extIndex,
  output logic             extWrStb,
  output logic      [7:0]  extWrData,
  input  wire logic [7:0]  extRdData,
  // Cursor and icon fine position
  output logic      [2:0]  fineHorizPos,
  output logic      [2:0]  fineVertPos,
  // Sequencer state
  output logic             seqRun,
  output logic             memRefreshEn,
  output logic             syncRun,
  output logic             screenBlank,
  output logic             charMapClear,
  // Dot and character timing
  output logic             dotEn,
  output logic             charEn,
  output logic             shiftLoad
);
  logic [7:0] indexByte_reg;
  logic [7:0] resetCtrl_reg;
  logic [7:0] clkMode_reg;
  logic       idxWr;
  logic       dataWr;
  logic       dataRd;
  logic       fineIdx;
  logic       extSel;
  logic       runNow;
  logic [7:0] rdMux;

  assign idxWr  = ioWrStb && (ioAddr == seq_ctrl_pkg::IO_INDEX_PORT);
  assign dataWr = ioWrStb && (ioAddr == seq_ctrl_pkg::IO_DATA_PORT);
  assign dataRd = ioRdStb && (ioAddr == seq_ctrl_pkg::IO_DATA_PORT);
  assign extSel = extIndex > seq_ctrl_pkg::IDX_STD_LAST;
  assign runNow = resetCtrl_reg[seq_ctrl_pkg::RST_SYNC_BIT] &&
                  resetCtrl_reg[seq_ctrl_pkg::RST_ASYNC_BIT];
  assign fineIdx = (ioWrData[4:0] == seq_ctrl_pkg::IDX_CURSOR_HORIZ) ||
                   (ioWrData[4:0] == seq_ctrl_pkg::IDX_CURSOR_VERT);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      indexByte_reg <= seq_ctrl_pkg::INDEX_RESET;
    end else if (idxWr) begin
      indexByte_reg <= ioWrData;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      extIndex <= seq_ctrl_pkg::INDEX_RESET[5:0];
    end else if (idxWr && fineIdx) begin
      extIndex <= {1'b0, ioWrData[4:0]};
    end else if (idxWr) begin
      extIndex <= ioWrData[5:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resetCtrl_reg <= seq_ctrl_pkg::RESET_CTRL_RESET;
    end else if (dataWr && extIndex == seq_ctrl_pkg::IDX_RESET_CTRL) begin
      resetCtrl_reg <= ioWrData & seq_ctrl_pkg::RESET_CTRL_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clkMode_reg <= seq_ctrl_pkg::CLK_MODE_RESET;
    end else if (dataWr && extIndex == seq_ctrl_pkg::IDX_CLK_MODE) begin
      clkMode_reg <= ioWrData & seq_ctrl_pkg::CLK_MODE_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fineHorizPos <= 3'h0;
      fineVertPos  <= 3'h0;
    end else if (dataWr) begin
      if (extIndex == {1'b0, seq_ctrl_pkg::IDX_CURSOR_HORIZ}) begin
        fineHorizPos <= indexByte_reg[7:seq_ctrl_pkg::FINE_LSB];
      end else if (extIndex == {1'b0, seq_ctrl_pkg::IDX_CURSOR_VERT}) begin
        fineVertPos <= indexByte_reg[7:seq_ctrl_pkg::FINE_LSB];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      extWrStb  <= 1'b0;
      extWrData <= 8'h00;
    end else begin
      extWrStb  <= dataWr && extSel;
      extWrData <= dataWr ? ioWrData : extWrData;
    end
  end

  // Read multiplexer, reserved and unmapped read zero
  always_comb begin
    rdMux = 8'h00;
    if (ioAddr == seq_ctrl_pkg::IO_INDEX_PORT) begin
      rdMux = indexByte_reg;
    end else if (extSel) begin
      rdMux = extRdData;
    end else if (extIndex == seq_ctrl_pkg::IDX_RESET_CTRL) begin
      rdMux = resetCtrl_reg;
    end else if (extIndex == seq_ctrl_pkg::IDX_CLK_MODE) begin
      rdMux = clkMode_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ioRdData  <= 8'h00;
      ioRdValid <= 1'b0;
    end else begin
      ioRdValid <= ioRdStb && (dataRd ||
                   ioAddr == seq_ctrl_pkg::IO_INDEX_PORT);
      ioRdData  <= ioRdStb ? rdMux : ioRdData;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seqRun       <= 1'b0;
      memRefreshEn <= 1'b0;
      syncRun      <= 1'b0;
      screenBlank  <= 1'b1;
      charMapClear <= 1'b1;
    end else begin
      seqRun       <= runNow;
      memRefreshEn <= runNow;
      syncRun      <= runNow;
      screenBlank  <= !runNow ||
                      clkMode_reg[seq_ctrl_pkg::CM_FULL_BW_BIT];
      charMapClear <= !resetCtrl_reg[seq_ctrl_pkg::RST_ASYNC_BIT];
    end
  end

  seq_clock_gen uClockGen (
    .clk      (clk),
    .rst_b    (rst_b),
    .run      (runNow),
    .divBy2   (clkMode_reg[seq_ctrl_pkg::CM_DIV2_BIT]),
    .eightDot (clkMode_reg[seq_ctrl_pkg::CM_EIGHT_DOT_BIT]),
    .load16   (clkMode_reg[seq_ctrl_pkg::CM_LOAD16_BIT]),
    .load32   (clkMode_reg[seq_ctrl_pkg::CM_LOAD32_BIT]),
    .dotEn    (dotEn),
    .charEn   (charEn),
    .loadEn   (shiftLoad)
  );

  AST_INDEX_SIX_BIT: assert property (@(posedge clk)
    disable iff (!rst_b)
    idxWr && !fineIdx |=> extIndex == $past(ioWrData[5:0]))
    else $error("index not taken from low six bits");

  AST_READ_VALID: assert property (@(posedge clk)
    disable iff (!rst_b)
    dataRd |=> ioRdValid)
    else $error("data port read not answered");

  AST_INDEX_FINE: assert property (@(posedge clk)
    disable iff (!rst_b)
    idxWr && fineIdx |=> extIndex[5] == 1'b0 &&
      indexByte_reg[7:5] == $past(ioWrData[7:5]))
    else $error("fine index write handled wrongly");

  AST_SYNC_HALT: assert property (@(posedge clk)
    disable iff (!rst_b)
    !resetCtrl_reg[seq_ctrl_pkg::RST_SYNC_BIT] |=>
      !seqRun && !memRefreshEn && !dotEn)
    else $error("sequencer runs with synchronous reset low");

  AST_ASYNC_CLEAR: assert property (@(posedge clk)
    disable iff (!rst_b)
    !resetCtrl_reg[seq_ctrl_pkg::RST_ASYNC_BIT] |=>
      charMapClear && !seqRun)
    else $error("async reset low without halt and clear");

  AST_ASYNC_RELEASE: assert property (@(posedge clk)
    disable iff (!rst_b)
    resetCtrl_reg[seq_ctrl_pkg::RST_ASYNC_BIT] |=> !charMapClear)
    else $error("character map clear held with async bit set");

  AST_RUN_BOTH: assert property (@(posedge clk)
    disable iff (!rst_b)
    runNow |=> seqRun && !charMapClear)
    else $error("sequencer not running with both bits set");

  AST_HALT_OTHERWISE: assert property (@(posedge clk)
    disable iff (!rst_b)
    !runNow |=> !seqRun && !syncRun && screenBlank)
    else $error("sequencer running without both bits set");

  AST_FULL_BW_BLANK: assert property (@(posedge clk)
    disable iff (!rst_b)
    runNow && clkMode_reg[seq_ctrl_pkg::CM_FULL_BW_BIT] |=>
      screenBlank && syncRun && memRefreshEn)
    else $error("full bandwidth did not blank with syncs on");

  AST_FULL_BW_OFF: assert property (@(posedge clk)
    disable iff (!rst_b)
    runNow && !clkMode_reg[seq_ctrl_pkg::CM_FULL_BW_BIT] |=> !screenBlank)
    else $error("screen blanked in normal operation");

  AST_LOAD_EVERY: assert property (@(posedge clk)
    disable iff (!rst_b)
    !clkMode_reg[seq_ctrl_pkg::CM_LOAD32_BIT] &&
      !clkMode_reg[seq_ctrl_pkg::CM_LOAD16_BIT] &&
      $stable(clkMode_reg) &&
      $past(clkMode_reg) == $past(clkMode_reg, 2) &&
      charEn |-> shiftLoad)
    else $error("shifter not loaded every character clock");

  AST_EXT_ROUTE: assert property (@(posedge clk)
    disable iff (!rst_b)
    dataWr |=> extWrStb == ($past(extIndex) > seq_ctrl_pkg::IDX_STD_LAST))
    else $error("extension write routing wrong");

  AST_EXT_READ: assert property (@(posedge clk)
    disable iff (!rst_b)
    dataRd && extSel |=> ioRdData == $past(extRdData))
    else $error("extension read data not returned");

  AST_EXT_NO_STD: assert property (@(posedge clk)
    disable iff (!rst_b)
    dataWr && extSel |=> $stable(resetCtrl_reg) && $stable(clkMode_reg))
    else $error("extension write changed a standard register");

  AST_FINE_HORIZ: assert property (@(posedge clk)
    disable iff (!rst_b)
    dataWr && extIndex == {1'b0, seq_ctrl_pkg::IDX_CURSOR_HORIZ} |=>
      fineHorizPos == $past(indexByte_reg[7:5]) && $stable(fineVertPos))
    else $error("horizontal fine position not captured");

  AST_FINE_VERT: assert property (@(posedge clk)
    disable iff (!rst_b)
    dataWr && extIndex == {1'b0, seq_ctrl_pkg::IDX_CURSOR_VERT} |=>
      fineVertPos == $past(indexByte_reg[7:5]) && $stable(fineHorizPos))
    else $error("vertical fine position not captured");

  AST_RST_MASK: assert property (@(posedge clk)
    disable iff (!rst_b)
    dataWr && extIndex == seq_ctrl_pkg::IDX_RESET_CTRL |=>
      resetCtrl_reg == ($past(ioWrData) & seq_ctrl_pkg::RESET_CTRL_MASK))
    else $error("reset control reserved bits stored");

  AST_RESERVED_ZERO: assert property (@(posedge clk)
    disable iff (!rst_b)
    ioRdValid && $past(extIndex) == seq_ctrl_pkg::IDX_CLK_MODE &&
      $past(ioAddr) == seq_ctrl_pkg::IO_DATA_PORT |->
      (ioRdData & ~seq_ctrl_pkg::CLK_MODE_MASK) == 8'h00)
    else $error("reserved bits read non-zero");
endmodule
`default_nettype wire

/* sim/seq_reset_clock_ctrl_test.sv */
// Self-checking bench for sequencer index, reset and clocking registers
`default_nettype none
module seq_reset_clock_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [15:0] ioAddr = 16'h0000;
  logic        ioWrStb = 1'b0;
  logic        ioRdStb = 1'b0;
  logic [7:0]  ioWrData = 8'h00;
  logic [7:0]  extRdData = 8'h00;
  logic [7:0]  ioRdData;
  logic [7:0]  extWrData;
  logic [5:0]  extIndex;
  logic [2:0]  fineHorizPos;
  logic [2:0]  fineVertPos;
  logic        ioRdValid, extWrStb, seqRun, memRefreshEn, syncRun;
  logic        screenBlank, charMapClear, dotEn, charEn, shiftLoad;
  int          nFail = 0;
  int          testsRun = 0;

  always #20 clk = ~clk;

  seq_reset_clock_ctrl DUT (
    .clk, .rst_b, .ioAddr, .ioWrStb, .ioRdStb, .ioWrData, .ioRdData,
    .ioRdValid, .extIndex, .extWrStb, .extWrData, .extRdData,
    .fineHorizPos, .fineVertPos, .seqRun, .memRefreshEn, .syncRun,
    .screenBlank, .charMapClear, .dotEn, .charEn, .shiftLoad
  );

  task automatic stopTest;
    if (nFail == 0 && testsRun > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    testsRun++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      nFail++;
    end
  endtask

  task automatic timedOut(input string what);
    $display("MISMATCH %s expected pulse seen none", what);
    nFail++;
    stopTest();
  endtask

  // Idles one cycle, drives at a falling edge, returns at the next one
  task automatic ioWrite(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    ioAddr = a;
    ioWrData = d;
    ioWrStb = 1'b1;
    @(negedge clk);
    ioWrStb = 1'b0;
  endtask

  task automatic ioRead(input logic [15:0] a, output logic [7:0] d);
    int i;
    ioAddr = a;
    ioRdStb = 1'b1;
    @(negedge clk);
    ioRdStb = 1'b0;
    for (i = 0; i < 4 && ioRdValid !== 1'b1; i++) @(negedge clk);
    if (ioRdValid !== 1'b1) timedOut("ioRdValid");
    d = ioRdData;
    @(negedge clk);
  endtask

  function automatic logic pick(input int sel);
    return sel == 0 ? charEn : (sel == 1 ? shiftLoad : dotEn);
  endfunction

  // Cycles between the second and third pulse seen after the task starts
  task automatic gap(input string what, input int sel, input int exp);
    int n;
    int k;
    for (k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
        if (n > 200) timedOut(what);
      end while (pick(sel) !== 1'b1);
    end
    check(what, exp[7:0], n[7:0]);
  endtask

  task automatic resetValues;
    logic [7:0] d;
    check("seqRun", 8'h00, {7'h00, seqRun});
    check("screenBlank", 8'h01, {7'h00, screenBlank});
    check("charMapClear", 8'h01, {7'h00, charMapClear});
    ioRead(seq_ctrl_pkg::IO_INDEX_PORT, d);
    check("index reset", 8'h04, d);
    ioRead(seq_ctrl_pkg::IO_DATA_PORT, d);
    check("idx4 read", 8'h00, d);
  endtask

  task automatic resetCtrl;
    logic [7:0] d;
    logic [7:0] v;
    logic       run;
    ioWrite(seq_ctrl_pkg::IO_INDEX_PORT, 8'h00);
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 8'hFF : i[7:0] - 8'h01;
      run = (i == 0) || (i == 4);
      ioWrite(seq_ctrl_pkg::IO_DATA_PORT, v);
      repeat (2) @(negedge clk);
      check("seqRun", {7'h00, run}, seqRun);
      check("memRefreshEn", {7'h00, run}, memRefreshEn);
      check("syncRun", {7'h00, run}, {7'h00, syncRun});
      check("screenBlank", {7'h00, !run}, screenBlank);
      check("charMapClear", {7'h00, !v[0]}, charMapClear);
    end
    ioRead(seq_ctrl_pkg::IO_DATA_PORT, d);
    check("reset ctrl read", 8'h03, d);
  endtask

  task automatic clockMode;
    logic [7:0] d;
    logic [7:0] mode [6] = '{8'h00, 8'h01, 8'h09, 8'h04, 8'h15, 8'h14};
    int dotG [6] = '{1, 1, 2, 1, 1, 1};
    int charG [6] = '{9, 8, 16, 9, 8, 9};
    int loadG [6] = '{9, 8, 16, 18, 32, 36};
    ioWrite(seq_ctrl_pkg::IO_INDEX_PORT, 8'h01);
    ioWrite(seq_ctrl_pkg::IO_DATA_PORT, 8'hFF);
    ioRead(seq_ctrl_pkg::IO_DATA_PORT, d);
    check("clock mode read", 8'h3D, d);
    check("full bw blank", 8'h01, {7'h00, screenBlank});
    check("full bw sync", 8'h01, {7'h00, syncRun});
    check("full bw refresh", 8'h01, {7'h00, memRefreshEn});
    for (int i = 0; i < 6; i++) begin
      ioWrite(seq_ctrl_pkg::IO_DATA_PORT, mode[i]);
      gap("dotEn gap", 2, dotG[i]);
      gap("charEn gap", 0, charG[i]);
      gap("shiftLoad gap", 1, loadG[i]);
      check("screenBlank", 8'h00, {7'h00, screenBlank});
    end
  endtask

  task automatic indexPath;
    logic [7:0] d;
    ioWrite(seq_ctrl_pkg::IO_INDEX_PORT, 8'hE6);
    check("extIndex", 8'h26, {2'h0, extIndex});
    extRdData = 8'h5A;
    ioRead(seq_ctrl_pkg::IO_DATA_PORT, d);
    check("ext read", 8'h5A, d);
    ioWrite(seq_ctrl_pkg::IO_DATA_PORT, 8'h3C);
    check("extWrStb", 8'h01, {7'h00, extWrStb});
    check("extWrData", 8'h3C, extWrData);
    ioRead(seq_ctrl_pkg::IO_INDEX_PORT, d);
    check("index read", 8'hE6, d);
    ioWrite(seq_ctrl_pkg::IO_INDEX_PORT, 8'hB0);
    check("horiz index", 8'h10, {2'h0, extIndex});
    ioWrite(seq_ctrl_pkg::IO_DATA_PORT, 8'h00);
    check("fineHorizPos", 8'h05, {5'h00, fineHorizPos});
    ioWrite(seq_ctrl_pkg::IO_INDEX_PORT, 8'h71);
    check("vert index", 8'h11, {2'h0, extIndex});
    ioWrite(seq_ctrl_pkg::IO_DATA_PORT, 8'h00);
    check("fineVertPos", 8'h03, {5'h00, fineVertPos});
    check("fineHorizPos", 8'h05, {5'h00, fineHorizPos});
  endtask

  initial begin
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    resetValues();
    resetCtrl();
    clockMode();
    indexPath();
    stopTest();
  end
endmodule
`default_nettype wire
